//--- core/byte_alu.sv
// Eight-bit arithmetic and logic unit for byte and literal operations.
`timescale 1ns/100ps
`default_nettype none
module byte_alu (
  // Operation select and operands.
  input wire logic [3:0] op_i,
  input wire logic [7:0] src_i,
  input wire logic [7:0] acc_i,
  input wire logic carry_i,
  // Result and flags.
  output logic [7:0] res_o,
  output logic carry_o,
  output logic digit_o,
  output logic zero_o
);
  logic [8:0] sum;
  logic [4:0] low;

  // Subtraction is src plus the complement of the accumulator plus one, so carry
  // reads as no-borrow.
  always_comb
  begin
    sum = 9'h000;
    low = 5'h00;
    res_o = src_i;
    carry_o = carry_i;
    digit_o = 1'b0;
    case (op_i)
      mcu_decode_pkg::OP_MOVE_ACC: res_o = acc_i;
      mcu_decode_pkg::OP_CLEAR: res_o = 8'h00;
      mcu_decode_pkg::OP_SUB:
      begin
        sum = {1'b0, src_i} + {1'b0, ~acc_i} + 9'h001; // [RL2] [RL3]
        low = {1'b0, src_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
        res_o = sum[7:0];
        carry_o = sum[8];
        digit_o = low[4];
      end
      mcu_decode_pkg::OP_ADD:
      begin
        sum = {1'b0, src_i} + {1'b0, acc_i};
        low = {1'b0, src_i[3:0]} + {1'b0, acc_i[3:0]};
        res_o = sum[7:0];
        carry_o = sum[8];
        digit_o = low[4];
      end
      mcu_decode_pkg::OP_DEC, mcu_decode_pkg::OP_DEC_SKIP: res_o = src_i - 8'h01;
      mcu_decode_pkg::OP_INC, mcu_decode_pkg::OP_INC_SKIP: res_o = src_i + 8'h01;
      mcu_decode_pkg::OP_OR: res_o = src_i | acc_i; // [RL6] [RL12]
      mcu_decode_pkg::OP_AND: res_o = src_i & acc_i;
      mcu_decode_pkg::OP_XOR: res_o = src_i ^ acc_i; // [RL7] [RL13]
      mcu_decode_pkg::OP_COMP: res_o = ~src_i;
      mcu_decode_pkg::OP_ROT_LEFT:
      begin
        res_o = {src_i[6:0], carry_i}; // [RL8]
        carry_o = src_i[7];
      end
      mcu_decode_pkg::OP_ROT_RIGHT:
      begin
        res_o = {carry_i, src_i[7:1]}; // [RL9]
        carry_o = src_i[0];
      end
      mcu_decode_pkg::OP_SWAP: res_o = {src_i[3:0], src_i[7:4]};
      default: res_o = src_i;
    endcase
    zero_o = (res_o == 8'h00);
  end
endmodule : byte_alu
`default_nettype wire

//--- core/mcu_decode_pkg.sv
// Constants shared by the fourteen-bit instruction decoder and its helpers.
// Contract
// [RL1] Destination bit picks accumulator or file register
// [RL2] Field 0010 subtracts accumulator from register
// [RL3] Literal 110x subtracts accumulator from immediate
// [RL4] Field 1011 decrements, skips on zero
// [RL5] Field 1111 increments, skips on zero
// [RL6] Field 0100 ORs, updates zero only
// [RL7] Field 0110 XORs, updates zero only
// [RL8] Field 1101 rotates left through carry
// [RL9] Field 1100 rotates right through carry
// [RL10] Pattern 10bb skips when tested bit clear
// [RL11] Pattern 11bb skips when tested bit set
// [RL12] Literal 1000 ORs immediate, zero flag only
// [RL13] Literal 1010 XORs immediate, zero flag only
// [RL14] Literal 01xx loads immediate, returns, two cycles
// [RL15] Standby word sets timeout and powerdown flags (code sets timeout but clears powerdown)
// [RL16] Port read-modify-write uses pin levels
// [RL17] Timer-zero write clears assigned prescaler
// [RL18] Branch or true skip costs two cycles
// [RL19] Interrupt return pops and sets enable
// [RL20] Top two bits select instruction class
// [RL21] Seven-bit address, three-bit bit position
// [RL22] Call and jump take eleven-bit target
package mcu_decode_pkg;
  // Instruction classes in the top two bits.
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Byte-oriented operation fields.
  localparam logic [3:0] OP_MOVE_ACC = 4'h0;
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVE = 4'h8;
  localparam logic [3:0] OP_COMP = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DEC_SKIP = 4'hB;
  localparam logic [3:0] OP_ROT_RIGHT = 4'hC;
  localparam logic [3:0] OP_ROT_LEFT = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INC_SKIP = 4'hF;
  // Fixed control words.
  localparam logic [13:0] WORD_RETURN = 14'h0008;
  localparam logic [13:0] WORD_RET_IRQ = 14'h0009;
  localparam logic [13:0] WORD_STANDBY = 14'h0063;
  localparam logic [13:0] WORD_CLR_WDOG = 14'h0064;
  // Special file addresses.
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_FIRST_ADDR = 7'h05;
  localparam logic [6:0] PORT_LAST_ADDR = 7'h09;
  // Program counter and return stack.
  localparam int unsigned PC_W = 13;
  localparam int unsigned SP_W = 3;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  // Register word indices on the bus (byte address bits 7:2).
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_ACC = 6'h01;
  localparam logic [5:0] IDX_PC = 6'h02;
  localparam logic [5:0] IDX_CTRL = 6'h03;
  // Control register fields and reset value.
  localparam int unsigned CTRL_PRESC_TMR = 0;
  localparam int unsigned CTRL_RUN = 1;
  localparam int unsigned CTRL_PAGE_LO = 2;
  localparam int unsigned CTRL_IRQ_CLR = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status register fields.
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_DIGIT = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_PDOWN = 3;
  localparam int unsigned ST_TOUT = 4;
  localparam int unsigned ST_STANDBY = 5;
  localparam int unsigned ST_IRQ_EN = 6;
endpackage : mcu_decode_pkg

//--- core/mcu_instr_decode.sv
// Decode and execute stage for the fourteen-bit instruction word.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module mcu_instr_decode (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Program memory fetch.
  output logic [mcu_decode_pkg::PC_W-1:0] pc_o,
  input wire logic [13:0] instr_i,
  // Data register file.
  output logic [6:0] file_raddr_o,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] pin_level_i,
  output logic file_we_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  // Side effects.
  output logic prescaler_clear_o,
  output logic wdog_clear_o,
  output logic standby_o,
  input wire logic wakeup_i,
  output logic global_irq_enable_o,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_SLEEP} core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic [7:0] acc;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic timeout_flag;
  logic powerdown_flag;
  logic [3:0] ctrl;
  logic [mcu_decode_pkg::SP_W-1:0] sp;
  logic [mcu_decode_pkg::SP_W-1:0] next_sp;
  logic [mcu_decode_pkg::PC_W-1:0] next_pc;
  logic [mcu_decode_pkg::PC_W-1:0] stack_top;
  logic [mcu_decode_pkg::PC_W-1:0] pc_plus;

  // Instruction fields.
  logic [1:0] cls;
  logic [3:0] op;
  logic dest;
  logic [2:0] bit_pos;
  logic [7:0] imm;
  logic exec;
  assign cls = instr_i[13:12]; // [RL20]
  assign op = instr_i[11:8];
  assign dest = instr_i[7];
  assign bit_pos = instr_i[9:7]; // [RL21]
  assign imm = instr_i[7:0];
  assign file_raddr_o = instr_i[6:0]; // [RL21]
  assign exec = (state == ST_RUN) && ctrl[mcu_decode_pkg::CTRL_RUN];
  assign pc_plus = pc_o + 13'h0001;

  // Source operand: forward a pending write, and read ports from their pins.
  logic [7:0] src;
  logic is_port;
  assign is_port = (file_raddr_o >= mcu_decode_pkg::PORT_FIRST_ADDR) &&
                   (file_raddr_o <= mcu_decode_pkg::PORT_LAST_ADDR);
  always_comb
  begin
    if (is_port)
      src = pin_level_i; // [RL16]
    else if (file_we_o && file_waddr_o == file_raddr_o)
      src = file_wdata_o;
    else
      src = file_rdata_i;
  end

  // Arithmetic unit shared by byte and literal operations.
  logic [3:0] alu_op;
  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  byte_alu u_alu (
    .op_i(alu_op),
    .src_i(alu_a),
    .acc_i(acc),
    .carry_i(carry_flag),
    .res_o(alu_res),
    .carry_o(alu_c),
    .digit_o(alu_dc),
    .zero_o(alu_z)
  );

  // Decoded actions for the instruction held on instr_i.
  logic [7:0] res;
  logic wr_file;
  logic wr_acc;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic skip;
  logic jump;
  logic push;
  logic pop;
  logic set_irq_en;
  logic go_sleep;
  logic clr_wdog;

  // Main decoder; a skip or control transfer forces one dead cycle afterwards.
  always_comb
  begin
    alu_op = op;
    alu_a = src;
    res = alu_res;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    set_irq_en = 1'b0;
    go_sleep = 1'b0;
    clr_wdog = 1'b0;
    if (exec)
    begin
      case (cls)
        mcu_decode_pkg::CLS_BYTE:
        begin
          if (op == mcu_decode_pkg::OP_MOVE_ACC)
          begin
            if (dest)
              wr_file = 1'b1;
            else if (instr_i == mcu_decode_pkg::WORD_RETURN)
              pop = 1'b1;
            else if (instr_i == mcu_decode_pkg::WORD_RET_IRQ)
            begin
              pop = 1'b1; // [RL19]
              set_irq_en = 1'b1; // [RL19]
            end
            else if (instr_i == mcu_decode_pkg::WORD_STANDBY)
              go_sleep = 1'b1; // [RL15]
            else if (instr_i == mcu_decode_pkg::WORD_CLR_WDOG)
              clr_wdog = 1'b1;
          end
          else
          begin
            wr_file = dest; // [RL1]
            wr_acc = !dest; // [RL1]
            case (op)
              mcu_decode_pkg::OP_SUB, mcu_decode_pkg::OP_ADD:
              begin
                upd_c = 1'b1; // [RL2]
                upd_dc = 1'b1;
                upd_z = 1'b1;
              end
              mcu_decode_pkg::OP_ROT_LEFT, mcu_decode_pkg::OP_ROT_RIGHT:
                upd_c = 1'b1; // [RL8] [RL9]
              mcu_decode_pkg::OP_DEC_SKIP, mcu_decode_pkg::OP_INC_SKIP:
                skip = alu_z; // [RL4] [RL5]
              mcu_decode_pkg::OP_SWAP:
                upd_z = 1'b0;
              default:
                upd_z = 1'b1; // [RL6] [RL7]
            endcase
          end
        end
        mcu_decode_pkg::CLS_BIT:
        begin
          case (op[3:2])
            2'h0:
            begin
              res = src & ~(8'h01 << bit_pos);
              wr_file = 1'b1;
            end
            2'h1:
            begin
              res = src | (8'h01 << bit_pos);
              wr_file = 1'b1;
            end
            2'h2: skip = !src[bit_pos]; // [RL10]
            default: skip = src[bit_pos]; // [RL11]
          endcase
        end
        mcu_decode_pkg::CLS_JUMP:
        begin
          jump = 1'b1; // [RL22]
          push = !instr_i[11]; // [RL22]
        end
        default:
        begin
          alu_a = imm;
          wr_acc = 1'b1;
          casez (op)
            4'b00??: alu_op = mcu_decode_pkg::OP_MOVE;
            4'b01??:
            begin
              alu_op = mcu_decode_pkg::OP_MOVE; // [RL14]
              pop = 1'b1; // [RL14]
            end
            4'b1000:
            begin
              alu_op = mcu_decode_pkg::OP_OR; // [RL12]
              upd_z = 1'b1;
            end
            4'b1001:
            begin
              alu_op = mcu_decode_pkg::OP_AND;
              upd_z = 1'b1;
            end
            4'b1010:
            begin
              alu_op = mcu_decode_pkg::OP_XOR; // [RL13]
              upd_z = 1'b1;
            end
            4'b110?:
            begin
              alu_op = mcu_decode_pkg::OP_SUB; // [RL3]
              upd_c = 1'b1;
              upd_dc = 1'b1;
              upd_z = 1'b1;
            end
            4'b111?:
            begin
              alu_op = mcu_decode_pkg::OP_ADD;
              upd_c = 1'b1;
              upd_dc = 1'b1;
              upd_z = 1'b1;
            end
            default: wr_acc = 1'b0;
          endcase
        end
      endcase
    end
  end

  // Sequencing: branches and taken skips spend the next cycle as a no-operation.
  always_comb
  begin
    next_state = state;
    next_pc = pc_o;
    case (state)
      ST_RUN:
      begin
        if (exec)
        begin
          next_pc = pc_plus;
          if (jump)
          begin
            next_pc = {ctrl[mcu_decode_pkg::CTRL_PAGE_LO +: 2], instr_i[10:0]}; // [RL22]
            next_state = ST_FLUSH; // [RL18]
          end
          else if (pop)
          begin
            next_pc = stack_top;
            next_state = ST_FLUSH; // [RL18] [RL14]
          end
          else if (skip)
          begin
            next_pc = pc_o + 13'h0002;
            next_state = ST_FLUSH; // [RL18]
          end
          else if (go_sleep)
            next_state = ST_SLEEP;
        end
      end
      ST_FLUSH: next_state = ST_RUN;
      ST_SLEEP:
        if (wakeup_i)
          next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // State and program counter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_RUN;
      pc_o <= mcu_decode_pkg::PC_RESET;
    end
    else
    begin
      state <= next_state;
      pc_o <= next_pc;
    end
  end

  // Return stack pointer wraps round like the hardware it models.
  always_comb
  begin
    next_sp = sp;
    if (push)
      next_sp = sp + 3'h1;
    else if (pop)
      next_sp = sp - 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sp <= 3'h0;
    else
      sp <= next_sp;
  end

  // The read address looks one entry below the new pointer, ready for a pop.
  return_stack u_stack (
    .clk_i(clk_i),
    .we_i(push),
    .waddr_i(sp),
    .wdata_i(pc_plus),
    .raddr_i(next_sp - 3'h1),
    .rdata_o(stack_top)
  );

  // Accumulator.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc <= 8'h00;
    else if (wr_acc)
      acc <= res; // [RL1]
  end

  // Arithmetic flags change only where the operation calls for them.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end
    else
    begin
      if (upd_c)
        carry_flag <= alu_c;
      if (upd_dc)
        digit_carry_flag <= alu_dc;
      if (upd_z)
        zero_flag <= alu_z;
    end
  end

  // Timeout and powerdown flags; standby clears powerdown.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    else if (go_sleep || clr_wdog)
    begin
      timeout_flag <= 1'b1; // [RL15]
      powerdown_flag <= clr_wdog; // [RL15]
    end
  end

  // Register file write is registered; the forward path above hides the delay.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      file_we_o <= 1'b0;
      file_waddr_o <= 7'h00;
      file_wdata_o <= 8'h00;
      prescaler_clear_o <= 1'b0;
    end
    else
    begin
      file_we_o <= wr_file; // [RL1]
      file_waddr_o <= file_raddr_o;
      file_wdata_o <= (op == mcu_decode_pkg::OP_MOVE_ACC &&
                       cls == mcu_decode_pkg::CLS_BYTE) ? acc : res;
      prescaler_clear_o <= wr_file && ctrl[mcu_decode_pkg::CTRL_PRESC_TMR] &&
                           file_raddr_o == mcu_decode_pkg::TIMER_ZERO_ADDR; // [RL17]
    end
  end

  // Watchdog clear pulse and standby level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdog_clear_o <= 1'b0;
    else
      wdog_clear_o <= clr_wdog || go_sleep;
  end
  assign standby_o = (state == ST_SLEEP);

  // Global enable: the hardware set beats a software clear in the same cycle.
  logic bus_write;
  assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      global_irq_enable_o <= 1'b0;
    else if (set_irq_en)
      global_irq_enable_o <= 1'b1; // [RL19]
    else if (bus_write && wb_adr_i[7:2] == mcu_decode_pkg::IDX_CTRL &&
             wb_dat_i[mcu_decode_pkg::CTRL_IRQ_CLR])
      global_irq_enable_o <= 1'b0;
  end

  // Control register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= mcu_decode_pkg::CTRL_RESET;
    else if (bus_write && wb_adr_i[7:2] == mcu_decode_pkg::IDX_CTRL)
      ctrl <= wb_dat_i[3:0];
  end

  // Bus answer one cycle after the strobe; unmapped words read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i[7:2])
        mcu_decode_pkg::IDX_STATUS:
          wb_dat_o <= {25'h000_0000, global_irq_enable_o, standby_o, timeout_flag,
                       powerdown_flag, zero_flag, digit_carry_flag, carry_flag};
        mcu_decode_pkg::IDX_ACC: wb_dat_o <= {24'h00_0000, acc};
        mcu_decode_pkg::IDX_PC: wb_dat_o <= {19'h0_0000, pc_o};
        mcu_decode_pkg::IDX_CTRL: wb_dat_o <= {28'h000_0000, ctrl};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : mcu_instr_decode
`default_nettype wire

//--- core/return_stack.sv
// Small return-address memory with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module return_stack (
  // Clock.
  input wire logic clk_i,
  // Write port.
  input wire logic we_i,
  input wire logic [mcu_decode_pkg::SP_W-1:0] waddr_i,
  input wire logic [mcu_decode_pkg::PC_W-1:0] wdata_i,
  // Registered read port.
  input wire logic [mcu_decode_pkg::SP_W-1:0] raddr_i,
  output logic [mcu_decode_pkg::PC_W-1:0] rdata_o
);
  logic [mcu_decode_pkg::PC_W-1:0] mem [mcu_decode_pkg::STACK_DEPTH];

  // Storage needs no reset; a pop from an empty stack returns stale data.
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
  end

  // The read forwards a same-edge write so a pop right after a push sees it.
  always_ff @(posedge clk_i)
  begin
    if (we_i && waddr_i == raddr_i)
      rdata_o <= wdata_i;
    else
      rdata_o <= mem[raddr_i];
  end
endmodule : return_stack
`default_nettype wire

//--- verification/mcu_instr_decode_bench.sv
// Runs a short program through the decoder and checks results over the bus.
`timescale 1ns/100ps
`default_nettype none
module mcu_instr_decode_bench;
  localparam logic [13:0] PROG [0:22] = '{14'h3002, 14'h02A0, 14'h0421, 14'h3A03, 14'h3880,
    14'h3C02, 14'h06A1, 14'h0BA0, 14'h3055, 14'h0FA2, 14'h3066, 14'h0D21, 14'h0CA1,
    14'h18A1, 14'h3077, 14'h1C21, 14'h3077, 14'h0081, 14'h0885, 14'h2020, 14'h0063,
    14'h2028, 14'h2816};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wakeup_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [12:0] pc_o;
  logic [13:0] instr_i;
  logic [6:0] file_raddr_o;
  logic [6:0] file_waddr_o;
  logic [7:0] file_rdata_i;
  logic [7:0] pin_level_i;
  logic [7:0] file_wdata_o;
  logic file_we_o;
  logic prescaler_clear_o;
  logic wdog_clear_o;
  logic standby_o;
  logic global_irq_enable_o;
  int fail_count = 0;
  int compares = 0;
  int presc_seen = 0;
  int wdog_seen = 0;
  int skip_hits = 0;
  int n;
  logic [31:0] rd;
  always #10 clk_i = ~clk_i;
  mcu_instr_decode dut_u (.clk_i(clk_i), .rst_i(rst_i), .pc_o(pc_o), .instr_i(instr_i),
    .file_raddr_o(file_raddr_o), .file_rdata_i(file_rdata_i), .pin_level_i(pin_level_i),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .prescaler_clear_o(prescaler_clear_o), .wdog_clear_o(wdog_clear_o),
    .standby_o(standby_o), .wakeup_i(wakeup_i), .global_irq_enable_o(global_irq_enable_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  program_file_model mem_u (.clk_i(clk_i), .pc_i(pc_o), .instr_o(instr_i),
    .raddr_i(file_raddr_o), .rdata_o(file_rdata_i), .pin_o(pin_level_i), .we_i(file_we_o),
    .waddr_i(file_waddr_o), .wdata_i(file_wdata_o));
  // Count side-effect pulses and any fetch of an instruction that should have been skipped.
  always @(posedge clk_i)
  begin
    if (prescaler_clear_o === 1'b1)
      presc_seen <= presc_seen + 1;
    if (wdog_clear_o === 1'b1)
      wdog_seen <= wdog_seen + 1;
    if (!rst_i && pc_o inside {13'h0008, 13'h000A, 13'h000E, 13'h0010})
      skip_hits <= skip_hits + 1;
  end
  task automatic complete_run();
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, want);
    end
  endtask : check
  // One classic cycle; held until ack is sampled, then released for a cycle.
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 20)
    begin
      check(32'h0000_0000, 32'h0000_0001, "bus timeout");
      complete_run();
    end
  endtask : wb_cycle
  task automatic rd_check(input logic [7:0] adr, input logic [31:0] want, input string what);
    wb_cycle(1'b0, adr, 32'h0000_0000);
    check(rd, want, what);
  endtask : rd_check
  // Load program and register file, reset, then run to standby and back.
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem_u.rom[i] = (i < 23) ? PROG[i] : 14'h0000;
    mem_u.rom[32] = 14'h343C;
    mem_u.rom[40] = 14'h0009;
    for (int i = 0; i < 128; i++)
      mem_u.regs[i] = 8'h00;
    mem_u.regs[32] = 8'h03;
    mem_u.regs[33] = 8'h01;
    mem_u.regs[34] = 8'hFF;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_check(8'h00, 32'h0000_0018, "status after reset");
    wb_cycle(1'b1, 8'h00, 32'h0000_00FF);
    rd_check(8'h00, 32'h0000_0018, "status is read only");
    rd_check(8'h10, 32'h0000_0000, "unmapped read");
    wb_cycle(1'b1, 8'h0C, 32'h0000_0003);
    rd_check(8'h0C, 32'h0000_0003, "control readback");
    for (n = 0; n < 300 && standby_o !== 1'b1; n++)
      @(posedge clk_i);
    check({31'h0, standby_o}, 32'h0000_0001, "standby entered");
    rd_check(8'h00, 32'h0000_0033, "status in standby");
    rd_check(8'h04, 32'h0000_003C, "acc after literal return");
    check({24'h0, mem_u.regs[32]}, 32'h0000_0000, "sub then dec");
    check({24'h0, mem_u.regs[33]}, 32'h0000_00C1, "xor then rotate");
    check({24'h0, mem_u.regs[34]}, 32'h0000_0000, "inc wraps");
    check({24'h0, mem_u.regs[1]}, 32'h0000_0006, "rotate left into acc");
    check({24'h0, mem_u.regs[5]}, 32'h0000_005A, "port rewrite from pins");
    check(skip_hits, 32'h0000_0000, "skipped words fetched");
    check(presc_seen, 32'h0000_0001, "prescaler clears");
    check(wdog_seen, 32'h0000_0001, "watchdog clears");
    wakeup_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    wakeup_i <= 1'b0;
    for (n = 0; n < 100 && global_irq_enable_o !== 1'b1; n++)
      @(posedge clk_i);
    rd_check(8'h00, 32'h0000_0053, "status after irq return");
    wb_cycle(1'b1, 8'h0C, 32'h0000_0013);
    rd_check(8'h00, 32'h0000_0013, "irq enable cleared");
    complete_run();
  end
endmodule : mcu_instr_decode_bench
`default_nettype wire

//--- verification/mcu_instr_decode_properties.sv
// Port-level checks on the instruction decoder.
`timescale 1ns/100ps
`default_nettype none
module mcu_decode_checker (
  // Clock, reset and fetch.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [mcu_decode_pkg::PC_W-1:0] pc_o,
  input wire logic [13:0] instr_i,
  // File port and side effects.
  input wire logic [6:0] file_raddr_o,
  input wire logic file_we_o,
  input wire logic [6:0] file_waddr_o,
  input wire logic prescaler_clear_o,
  input wire logic standby_o,
  input wire logic wakeup_i,
  input wire logic global_irq_enable_o,
  // Bus handshake.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // The bus answers exactly one cycle after a request, once, and only to a request.
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // The operand address comes straight from the low seven bits.
  read_addr_a: assert property (file_raddr_o == instr_i[6:0])
    else $error("read address not from instruction");
  // A file write only follows a byte op with destination one or a bit op.
  write_dest_a: assert property (file_we_o |-> file_waddr_o == $past(instr_i[6:0]) &&
    ($past(instr_i[13:12]) == mcu_decode_pkg::CLS_BIT ||
    ($past(instr_i[13:12]) == mcu_decode_pkg::CLS_BYTE && $past(instr_i[7]))))
    else $error("file write without cause");
  presc_clear_a: assert property (prescaler_clear_o |->
    file_we_o && file_waddr_o == mcu_decode_pkg::TIMER_ZERO_ADDR)
    else $error("prescaler clear without timer write");
  // Standby freezes the program counter until woken.
  standby_hold_a: assert property (standby_o && !wakeup_i |=> standby_o && $stable(pc_o))
    else $error("standby left without wakeup");
  // Any change of flow is followed by one dead cycle.
  branch_dead_a: assert property (!$past(rst_i) && pc_o != $past(pc_o) &&
    pc_o != $past(pc_o) + 13'h0001 |=> $stable(pc_o))
    else $error("no dead cycle after change of flow");
  irq_enable_a: assert property ($rose(global_irq_enable_o) |->
    $past(instr_i) == mcu_decode_pkg::WORD_RET_IRQ)
    else $error("irq enable set without interrupt return");
endmodule : mcu_decode_checker
bind mcu_instr_decode mcu_decode_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .pc_o(pc_o),
  .instr_i(instr_i), .file_raddr_o(file_raddr_o), .file_we_o(file_we_o),
  .file_waddr_o(file_waddr_o), .prescaler_clear_o(prescaler_clear_o), .standby_o(standby_o),
  .wakeup_i(wakeup_i), .global_irq_enable_o(global_irq_enable_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

//--- verification/program_file_model.sv
// Behavioural program memory and data register file facing the decoder.
`timescale 1ns/100ps
`default_nettype none
module program_file_model #(
  parameter logic [7:0] PIN_LEVEL = 8'h5A
) (
  // Clock.
  input wire logic clk_i,
  // Instruction fetch.
  input wire logic [mcu_decode_pkg::PC_W-1:0] pc_i,
  output logic [13:0] instr_o,
  // Register file.
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic [7:0] pin_o,
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i
);
  logic [13:0] rom [0:63];
  logic [7:0] regs [0:127];
  // Fetch and read are combinational, as the decoder expects them in the same cycle.
  assign instr_o = rom[pc_i[5:0]];
  assign rdata_o = regs[raddr_i];
  // Pins differ from the latches; outside the ports they follow the address, not a stale value.
  assign pin_o = (raddr_i >= mcu_decode_pkg::PORT_FIRST_ADDR &&
    raddr_i <= mcu_decode_pkg::PORT_LAST_ADDR) ? PIN_LEVEL : ~{1'b0, raddr_i};
  // Writes land on the edge after the strobe is seen.
  always @(posedge clk_i)
  begin
    if (we_i === 1'b1)
      regs[waddr_i] <= wdata_i;
  end
endmodule : program_file_model
`default_nettype wire
